/* rtl/flc_pkg.sv */
// constants of the loop control register set
// assumes a plain register port, 8-bit address, 16-bit data
//
// How it works
// - bit 2 of enables picks integer (0) or fractional (1) multiply
// - output divide is code plus one, 4 to 64; codes 0-2 reserved
// - control block rate divides by code plus one, default 000
// - ratio 000-011 divides 1,2,4,8; 1XX divides 16; resets 111
// - 16-bit fraction, msb weighs one half, resets zero
// - 10-bit integer multiplier in bits 14:5, resets 177h
// - gain multiplies error by two to the code, x1 to x256
// - predivider bits 4:3 divide reference by 1,2,4,8
// - source bits 1:0 pick master, bit or frame clock; 11 reserved
package flc_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 16;
  localparam logic [7:0] ADDR_ENABLES = 8'h74;
  localparam logic [7:0] ADDR_DIVIDERS = 8'h75;
  localparam logic [7:0] ADDR_FRACTION = 8'h76;
  localparam logic [7:0] ADDR_INTEGER = 8'h77;
  localparam logic [7:0] ADDR_REFSEL = 8'h78;
  localparam logic [7:0] ADDR_STATUS = 8'h79;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned ENA_BIT = 0;
  localparam int unsigned OSC_BIT = 1;
  localparam int unsigned FRAC_BIT = 2;
  localparam int unsigned OUTDIV_LSB = 8;
  localparam int unsigned OUTDIV_MSB = 13;
  localparam int unsigned RATE_LSB = 4;
  localparam int unsigned RATE_MSB = 6;
  localparam int unsigned RATIO_LSB = 0;
  localparam int unsigned RATIO_MSB = 2;
  localparam int unsigned INT_LSB = 5;
  localparam int unsigned INT_MSB = 14;
  localparam int unsigned GAIN_LSB = 0;
  localparam int unsigned GAIN_MSB = 3;
  localparam int unsigned PREDIV_LSB = 3;
  localparam int unsigned PREDIV_MSB = 4;
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned SRC_MSB = 1;
  localparam int unsigned ST_REF_BIT = 0;
  localparam int unsigned ST_OUTDIV_BIT = 1;
  localparam int unsigned ST_SRC_BIT = 2;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [5:0] RST_OUTDIV = 6'h00;
  localparam logic [2:0] RST_RATE = 3'h0;
  localparam logic [2:0] RST_RATIO = 3'h7;
  localparam logic [15:0] RST_FRAC = 16'h0000;
  localparam logic [9:0] RST_INT = 10'h177;
  localparam logic [3:0] RST_GAIN = 4'h0;
  localparam logic [1:0] RST_PREDIV = 2'h0;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic [5:0] OUTDIV_MIN_CODE = 6'h03;
  localparam logic [3:0] GAIN_MAX_CODE = 4'h8;
  localparam logic [1:0] SRC_MCLK = 2'h0;
  localparam logic [1:0] SRC_BCLK = 2'h1;
  localparam logic [1:0] SRC_LRCLK = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
endpackage : flc_pkg

/* rtl/flc_regs.sv */
// loop control registers, decoded settings and reference predivider
// assumes one clock ref_clk, reference pins asynchronous to it
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module flc_regs (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [flc_pkg::AW-1:0] reg_addr,
  input wire logic [flc_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [flc_pkg::DW-1:0] reg_rdata,
  input wire logic mclk_pin,
  input wire logic bclk_pin,
  input wire logic lrclk_pin,
  output logic loop_enable,
  output logic loop_oscillator_enable,
  output logic fractional_mode_enable,
  output logic [6:0] output_divide,
  output logic [3:0] control_rate_divide,
  output logic [4:0] reference_ratio_divide,
  output logic [9:0] multiplier_integer,
  output logic [15:0] multiplier_fraction,
  output logic [8:0] loop_gain_mult,
  output logic reference_divided,
  output logic reference_tick,
  output logic config_fault
);
  import flc_pkg::*;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  // divide by code plus one
  function automatic logic [6:0] out_div(input logic [5:0] c);
    out_div = {1'b0, c} + 7'h01;
  endfunction : out_div

  function automatic logic [3:0] rate_div(input logic [2:0] c);
    rate_div = {1'b0, c} + 4'h1;
  endfunction : rate_div

  // top code bit set means divide by sixteen
  function automatic logic [4:0] ratio_div(input logic [2:0] c);
    if (c[2]) begin
      ratio_div = 5'h10;
    end else begin
      ratio_div = 5'h01 << c[1:0];
    end
  endfunction : ratio_div

  // power of two, codes past the top saturate at x256
  function automatic logic [8:0] gain_mult(input logic [3:0] c);
    if (c > GAIN_MAX_CODE) begin
      gain_mult = 9'h100;
    end else begin
      gain_mult = 9'h001 << c;
    end
  endfunction : gain_mult

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] r);
    hit = (a == r);
  endfunction : hit

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic ena_q;
  logic osc_q;
  logic frac_q;
  logic [5:0] outdiv_q;
  logic [2:0] rate_q;
  logic [2:0] ratio_q;
  logic [15:0] k_q;
  logic [9:0] n_q;
  logic [3:0] gain_q;
  logic [1:0] prediv_q;
  logic [1:0] src_q;

  // enables word, all low after reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ena_q <= 1'b0;
      osc_q <= 1'b0;
      frac_q <= 1'b0;
    end else if (reg_wr && hit(reg_addr, ADDR_ENABLES)) begin
      ena_q <= reg_wdata[ENA_BIT];
      osc_q <= reg_wdata[OSC_BIT];
      frac_q <= reg_wdata[FRAC_BIT];
    end
  end

  // dividers word
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      outdiv_q <= RST_OUTDIV;
      rate_q <= RST_RATE;
      ratio_q <= RST_RATIO;
    end else if (reg_wr && hit(reg_addr, ADDR_DIVIDERS)) begin
      outdiv_q <= reg_wdata[OUTDIV_MSB:OUTDIV_LSB];
      rate_q <= reg_wdata[RATE_MSB:RATE_LSB];
      ratio_q <= reg_wdata[RATIO_MSB:RATIO_LSB];
    end
  end

  // fraction word
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      k_q <= RST_FRAC;
    end else if (reg_wr && hit(reg_addr, ADDR_FRACTION)) begin
      k_q <= reg_wdata;
    end
  end

  // integer and gain word
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      n_q <= RST_INT;
      gain_q <= RST_GAIN;
    end else if (reg_wr && hit(reg_addr, ADDR_INTEGER)) begin
      n_q <= reg_wdata[INT_MSB:INT_LSB];
      gain_q <= reg_wdata[GAIN_MSB:GAIN_LSB];
    end
  end

  // reference select word
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prediv_q <= RST_PREDIV;
      src_q <= RST_SRC;
    end else if (reg_wr && hit(reg_addr, ADDR_REFSEL)) begin
      prediv_q <= reg_wdata[PREDIV_MSB:PREDIV_LSB];
      src_q <= reg_wdata[SRC_MSB:SRC_LSB];
    end
  end

  // ----------------------------------------------------------------
  // decoded settings, registered
  // ----------------------------------------------------------------
  logic outdiv_bad;
  logic src_bad;

  assign outdiv_bad = (outdiv_q < OUTDIV_MIN_CODE);
  assign src_bad = (src_q == SRC_RSVD);

  // fraction only counts in fractional mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      loop_enable <= 1'b0;
      loop_oscillator_enable <= 1'b0;
      fractional_mode_enable <= 1'b0;
      multiplier_fraction <= RST_FRAC;
      multiplier_integer <= RST_INT;
    end else begin
      loop_enable <= ena_q;
      loop_oscillator_enable <= osc_q;
      fractional_mode_enable <= frac_q;
      multiplier_fraction <= frac_q ? k_q : RST_FRAC;
      multiplier_integer <= n_q;
    end
  end

  // divisors and gain
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      output_divide <= out_div(RST_OUTDIV);
      control_rate_divide <= rate_div(RST_RATE);
      reference_ratio_divide <= ratio_div(RST_RATIO);
      loop_gain_mult <= gain_mult(RST_GAIN);
      config_fault <= 1'b0;
    end else begin
      output_divide <= out_div(outdiv_q);
      control_rate_divide <= rate_div(rate_q);
      reference_ratio_divide <= ratio_div(ratio_q);
      loop_gain_mult <= gain_mult(gain_q);
      config_fault <= outdiv_bad | src_bad;
    end
  end

  // ----------------------------------------------------------------
  // reference pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] filt_q;

  assign pins = {lrclk_pin, bclk_pin, mclk_pin};

  // three stages, first read only by second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      filt_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // source select and predivider
  // ----------------------------------------------------------------
  logic sel_d;
  logic sel_q;
  logic sel_prev_q;
  logic [2:0] edge_cnt_q;
  logic div_d;
  logic ref_div_q;
  logic tick_q;

  // reserved source gives no reference
  always_comb begin
    case (src_q)
      SRC_MCLK: sel_d = filt_q[0];
      SRC_BCLK: sel_d = filt_q[1];
      SRC_LRCLK: sel_d = filt_q[2];
      default: sel_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      sel_prev_q <= sel_q;
    end
  end

  // counts rising reference edges, held clear while the loop is off
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      edge_cnt_q <= 3'h0;
    end else if (!ena_q) begin
      edge_cnt_q <= 3'h0;
    end else if (sel_q && !sel_prev_q) begin
      edge_cnt_q <= edge_cnt_q + 3'h1;
    end
  end

  // divide by one passes the level, else a counter bit
  always_comb begin
    case (prediv_q)
      2'h0: div_d = sel_q;
      2'h1: div_d = edge_cnt_q[0];
      2'h2: div_d = edge_cnt_q[1];
      default: div_d = edge_cnt_q[2];
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ref_div_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      ref_div_q <= ena_q & div_d;
      tick_q <= ena_q & div_d & ~ref_div_q;
    end
  end

  assign reference_divided = ref_div_q;
  assign reference_tick = tick_q;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [DW-1:0] rd_d;
  logic [DW-1:0] rdata_q;

  // unused bits and unmapped addresses read zero
  always_comb begin
    rd_d = '0;
    case (reg_addr)
      ADDR_ENABLES: begin
        rd_d[ENA_BIT] = ena_q;
        rd_d[OSC_BIT] = osc_q;
        rd_d[FRAC_BIT] = frac_q;
      end
      ADDR_DIVIDERS: begin
        rd_d[OUTDIV_MSB:OUTDIV_LSB] = outdiv_q;
        rd_d[RATE_MSB:RATE_LSB] = rate_q;
        rd_d[RATIO_MSB:RATIO_LSB] = ratio_q;
      end
      ADDR_FRACTION: rd_d = k_q;
      ADDR_INTEGER: begin
        rd_d[INT_MSB:INT_LSB] = n_q;
        rd_d[GAIN_MSB:GAIN_LSB] = gain_q;
      end
      ADDR_REFSEL: begin
        rd_d[PREDIV_MSB:PREDIV_LSB] = prediv_q;
        rd_d[SRC_MSB:SRC_LSB] = src_q;
      end
      ADDR_STATUS: begin
        rd_d[ST_REF_BIT] = ref_div_q;
        rd_d[ST_OUTDIV_BIT] = outdiv_bad;
        rd_d[ST_SRC_BIT] = src_bad;
      end
      default: rd_d = '0;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_d : '0;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_int_mode_zero: assert property (
    !frac_q |=> multiplier_fraction == 16'h0000)
    else $error("fraction not cleared in integer mode");

  a_frac_mode_pass: assert property (
    frac_q |=> multiplier_fraction == $past(k_q))
    else $error("fraction not passed in fractional mode");

  a_outdiv_plus_one: assert property (
    ##1 output_divide == ({1'b0, $past(outdiv_q)} + 7'h01))
    else $error("output divide not code plus one");

  a_rate_plus_one: assert property (
    ##1 control_rate_divide == ({1'b0, $past(rate_q)} + 4'h1))
    else $error("control rate not code plus one");

  a_ratio_top: assert property (
    ratio_q[2] |=> reference_ratio_divide == 5'h10)
    else $error("ratio 1XX not sixteen");

  a_ratio_low: assert property (
    !ratio_q[2] |=>
      reference_ratio_divide == (5'h01 << $past(ratio_q[1:0])))
    else $error("ratio low codes wrong");

  a_int_follow: assert property (
    reg_wr && hit(reg_addr, ADDR_INTEGER) |=> ##1
      multiplier_integer == $past(reg_wdata[INT_MSB:INT_LSB], 2))
    else $error("integer multiplier not updated");

  a_gain_power: assert property (
    gain_q <= GAIN_MAX_CODE |=>
      loop_gain_mult == (9'h001 << $past(gain_q)))
    else $error("gain not power of two");

  a_prediv_hold: assert property (
    !ena_q |=> !reference_tick && !reference_divided)
    else $error("reference active while loop off");

  a_src_reserved: assert property (
    src_bad |=> !sel_q && config_fault)
    else $error("reserved source not blocked");

  a_read_once: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside answer cycle");

  c_enable_seq: cover property (
    osc_q && !ena_q ##[1:50] ena_q);
  c_tick_div8: cover property (
    prediv_q == 2'h3 && reference_tick);
  c_frac_read: cover property (
    reg_rd && hit(reg_addr, ADDR_FRACTION) ##1 reg_rdata != '0);
endmodule : flc_regs

/* dv/flc_regs_tb.sv */
// self-checking testbench for the loop control register set
// assumes flc_regs on one 100 MHz clock, driven over its plain register port
`timescale 1ns/10ps
module flc_regs_tb;
  import flc_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset and design hookup
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] ref_pins = 3'h0; // frame, bit, master clock pins
  logic [15:0] reg_rdata;
  logic loop_enable, loop_oscillator_enable, fractional_mode_enable;
  logic [6:0] output_divide;
  logic [3:0] control_rate_divide;
  logic [4:0] reference_ratio_divide;
  logic [9:0] multiplier_integer;
  logic [15:0] multiplier_fraction;
  logic [8:0] loop_gain_mult;
  logic reference_divided, reference_tick, config_fault;
  int mismatches = 0;
  int check_count = 0;
  int ticks = 0;

  flc_regs dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mclk_pin(ref_pins[0]), .bclk_pin(ref_pins[1]), .lrclk_pin(ref_pins[2]),
    .loop_enable(loop_enable), .loop_oscillator_enable(loop_oscillator_enable),
    .fractional_mode_enable(fractional_mode_enable), .output_divide(output_divide),
    .control_rate_divide(control_rate_divide),
    .reference_ratio_divide(reference_ratio_divide),
    .multiplier_integer(multiplier_integer), .multiplier_fraction(multiplier_fraction),
    .loop_gain_mult(loop_gain_mult), .reference_divided(reference_divided),
    .reference_tick(reference_tick), .config_fault(config_fault)
  );

  // free-running 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // counts one-cycle reference ticks seen at the ports
  always @(posedge ref_clk) begin
    if (reference_tick === 1'b1) ticks <= ticks + 1;
  end

  // ----------------------------------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle write; strobe is left up so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr

  // one-cycle read; data compared in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, reg_rdata);
  endtask : rd

  // drop strobes and let n edges pass, then step off the edge
  task automatic cyc(input int n);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // n pulses, four cycles high and four low, on the pins in mask
  task automatic pulse(input logic [2:0] mask, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      ref_pins <= mask;
      repeat (4) @(posedge ref_clk);
      ref_pins <= 3'h0;
      repeat (3) @(posedge ref_clk);
    end
  endtask : pulse

  // select source and predivider, run 16 pin pulses, count ticks
  task automatic refrun(input logic [1:0] src, input logic [1:0] pdiv,
                        input logic [2:0] mask, input int exp);
    int t0;
    wr(ADDR_REFSEL, {11'h000, pdiv, 1'b0, src});
    wr(ADDR_ENABLES, 16'h0007);
    cyc(2);
    t0 = ticks;
    pulse(mask, 16);
    cyc(8);
    chk("tick count", exp[15:0], 16'(ticks - t0));
    wr(ADDR_ENABLES, 16'h0006);
    cyc(2);
    chk("divided level off", 16'h0000, {15'h0, reference_divided});
  endtask : refrun

  task automatic complete_run();
    $display("counts: checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // hang guard, far beyond the under 1400 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] addrs [5];
    logic [15:0] rst_vals [5];
    logic [15:0] masks [5];
    int t0;
    addrs = '{ADDR_ENABLES, ADDR_DIVIDERS, ADDR_FRACTION, ADDR_INTEGER, ADDR_REFSEL};
    rst_vals = '{16'h0000, 16'h0007, 16'h0000, 16'h2EE0, 16'h0000};
    masks = '{16'h0007, 16'h3F77, 16'hFFFF, 16'h7FEF, 16'h001B};
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(1);
    // reset values at the decoded outputs and in the registers
    chk("enables", 16'h0000, {13'h0, fractional_mode_enable, loop_oscillator_enable,
        loop_enable});
    chk("outdiv", 16'h0001, {9'h0, output_divide});
    chk("rate", 16'h0001, {12'h0, control_rate_divide});
    chk("ratio", 16'h0010, {11'h0, reference_ratio_divide});
    chk("fraction", 16'h0000, multiplier_fraction);
    chk("integer", 16'h0177, {6'h0, multiplier_integer});
    chk("gain", 16'h0001, {7'h0, loop_gain_mult});
    chk("fault", 16'h0001, {15'h0, config_fault});
    for (int i = 0; i < 5; i++) rd(addrs[i], rst_vals[i]);
    rd(ADDR_STATUS, 16'h0002);
    // all ones: reserved bits read zero, top codes decode
    wr(ADDR_ENABLES, 16'h0006);
    for (int i = 0; i < 5; i++) wr(addrs[i], 16'hFFFF);
    cyc(2);
    for (int i = 0; i < 5; i++) rd(addrs[i], masks[i]);
    chk("outdiv 63", 16'h0040, {9'h0, output_divide});
    chk("fraction on", 16'hFFFF, multiplier_fraction);
    chk("integer max", 16'h03FF, {6'h0, multiplier_integer});
    chk("gain saturated", 16'h0100, {7'h0, loop_gain_mult});
    chk("enables on", 16'h0007, {13'h0, fractional_mode_enable, loop_oscillator_enable,
        loop_enable});
    rd(ADDR_STATUS, 16'h0004);
    chk("fault src", 16'h0001, {15'h0, config_fault});
    // read-only and unmapped places ignore writes
    wr(ADDR_STATUS, 16'hFFFF);
    wr(8'h80, 16'hFFFF);
    rd(ADDR_STATUS, 16'h0004);
    rd(8'h80, 16'h0000);
    cyc(0);
    chk("read data idle", 16'h0000, reg_rdata);
    // integer mode clears the fraction; oscillator enabled alone first
    wr(ADDR_ENABLES, 16'h0002);
    wr(ADDR_FRACTION, 16'h3127);
    rd(ADDR_FRACTION, 16'h3127);
    cyc(1);
    chk("integer mode", 16'h0000, multiplier_fraction);
    chk("osc only", 16'h0002, {14'h0, loop_oscillator_enable, loop_enable});
    wr(ADDR_ENABLES, 16'h0007);
    wr(ADDR_INTEGER, 16'h0100);
    wr(ADDR_REFSEL, 16'h0000);
    wr(ADDR_DIVIDERS, 16'h0700);
    cyc(2);
    chk("outdiv 7", 16'h0008, {9'h0, output_divide});
    chk("fraction mode", 16'h3127, multiplier_fraction);
    chk("integer 8", 16'h0008, {6'h0, multiplier_integer});
    // ratio and rate codes with the lowest legal output divider
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_DIVIDERS, {8'h03, 1'b0, 3'(i), 1'b0, 3'(i)});
      cyc(2);
      chk("ratio", (i > 3) ? 16'h0010 : (16'h0001 << i), {11'h0, reference_ratio_divide});
      chk("rate", 16'(i + 1), {12'h0, control_rate_divide});
      chk("outdiv 3", 16'h0004, {9'h0, output_divide});
      chk("fault clear", 16'h0000, {15'h0, config_fault});
    end
    // gain codes 0 to 8
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_INTEGER, 16'(i));
      cyc(2);
      chk("gain", 16'h0001 << i, {7'h0, loop_gain_mult});
    end
    // reference path: each source, each predivider, wrong pin, reserved source
    wr(ADDR_ENABLES, 16'h0006);
    cyc(2);
    t0 = ticks;
    pulse(3'h1, 4);
    cyc(8);
    chk("ticks loop off", 16'h0000, 16'(ticks - t0));
    refrun(2'h0, 2'h0, 3'h1, 16);
    refrun(2'h1, 2'h0, 3'h2, 16);
    refrun(2'h2, 2'h0, 3'h4, 16);
    refrun(2'h1, 2'h0, 3'h1, 0);
    refrun(2'h0, 2'h1, 3'h1, 8);
    refrun(2'h0, 2'h2, 3'h1, 4);
    refrun(2'h0, 2'h3, 3'h1, 2);
    refrun(2'h3, 2'h0, 3'h7, 0);
    complete_run();
  end
endmodule : flc_regs_tb
